// >>> verilog/lsfd_frame_decoder.sv
// Behaviour
// R1: 8-bit error register, four low flags
// R2: Checksum, stop or length fault sets data
// R3: Parity or sync fault sets header flag
// R4: Full status query clears error register
// R5: Address from straps high, memory bits low
// R6: Identifier then 2, 4 or 8 bytes
// R7: Frame 0x3C carries marker, command, address
// R8: Master keeps first 0x3C byte bit7 high
// R9: General frame: byte1 command, broadcast executes
// R10: Select set: execute only on address match
// R11: Application-bound writes accepted by any node
// R12: Node-bound 2-byte writes accepted here
// R13: Reading frame answered with data and checksum
// R14: Indirect read only right after prepare
// R15: Every response carries own node address
// R16: Direct read identifier answered without prepare
// R17: Identifier 0x3D answered only when prepared
// R18: Prepare arms only on address match
// R19: 2-byte prepare: bit5 zero, command, address
// R20: 0x3C prepare: marker, command, address, data
// R21: Second byte command only after marker 0x80
// R22: Identifier has six bits, two parity
// R23: Select zero all act, else match
// R24: Readback mismatch while sending sets bit
// R25: Flags stay set until query or reset
`include "lsfd_params.svh"
module lsfd_frame_decoder import lsfd_pkg::*; (
    input wire logic MCLK,
    input wire logic RESET_N,
    input wire logic PROG_ADDR_BIT0,
    input wire logic PROG_ADDR_BIT1,
    input wire logic PROG_ADDR_BIT2,
    input wire logic PROG_ADDR_BIT3,
    input wire logic STRAP_ADDR_PIN0,
    input wire logic STRAP_ADDR_PIN1,
    input wire logic STRAP_ADDR_PIN2,
    input wire lsfd_idmap_t ID_MAP,
    input wire logic HDR_VALID,
    input wire logic [7:0] HDR_ID,
    input wire logic SYNC_ERR,
    input wire logic RX_VALID,
    input wire logic [7:0] RX_BYTE,
    input wire logic RX_STOP_ERR,
    input wire logic FRAME_END,
    input wire logic CHKSUM_OK,
    input wire logic TIMEOUT_ERR,
    input wire logic TX_BIT_VALID,
    input wire logic TX_BIT_SENT,
    input wire logic TX_BIT_READ,
    output logic CMD_VALID,
    output lsfd_cmd_t CMD,
    output logic RESP_REQ,
    output lsfd_resp_t RESP,
    output logic [7:0] ERR_FLAGS,
    output logic [6:0] NODE_ADDR
);
    // =====================================================
    // Declarations
    lsfd_state_t st_q; // Frame handling state
    lsfd_state_t hdr_st; // State chosen by header
    lsfd_kind_t kind_q; // Writing frame kind
    lsfd_kind_t hdr_kind; // Kind chosen by header
    logic [3:0] len_q; // Expected data length
    logic [3:0] hdr_len; // Length from header
    logic [3:0] cnt_q; // Bytes received, saturating
    logic [7:0] buf_q [8]; // Received data bytes
    logic stop_q; // Stop fault seen in frame
    logic prep_q; // Response armed for next frame
    logic [6:0] prep_cmd_q; // Armed read command
    logic [6:0] resp_cmd; // Read command from header
    logic [5:0] hid; // Six identifier bits
    logic hdr_ok; // Parity good
    logic len_ok; // Byte count as expected
    logic rx_good; // Writing frame clean at end
    logic exec; // Frame executes a command
    logic arm; // Frame prepares a response
    logic [6:0] code; // Command code to hand out
    logic [63:0] data_w; // Flattened data field
    logic [3:0] err_set; // Error events this cycle
    logic err_clr; // Full status query taken

    assign hid = HDR_ID[5:0];

    // =====================================================
    // Identifier parity, six bits plus two
    function automatic logic parity_ok(input logic [7:0] id);
        logic p0;
        logic p1;
        p0 = id[0] ^ id[1] ^ id[2] ^ id[4];
        p1 = ~(id[1] ^ id[3] ^ id[4] ^ id[5]);
        return (id[6] == p0) && (id[7] == p1); // [R22]
    endfunction

    // Length code in identifier bits 5 and 4
    function automatic logic [3:0] id_len(input logic [1:0] c);
        case (c)
            2'h2: return `LSFD_LEN4;
            2'h3: return `LSFD_LEN8;
            default: return `LSFD_LEN2; // [R6]
        endcase
    endfunction

    // Address byte matches this node
    function automatic logic hit(input logic [7:0] b);
        return b[6:0] == NODE_ADDR;
    endfunction

    // =====================================================
    // Node address and error register
    lsfd_node_addr u_addr (
        .clk(MCLK),
        .rst_n(RESET_N),
        .prog({PROG_ADDR_BIT3, PROG_ADDR_BIT2, PROG_ADDR_BIT1,
            PROG_ADDR_BIT0}),
        .pin({STRAP_ADDR_PIN2, STRAP_ADDR_PIN1, STRAP_ADDR_PIN0}),
        .addr(NODE_ADDR)
    );

    lsfd_err_reg u_err (
        .clk(MCLK),
        .rst_n(RESET_N),
        .set(err_set),
        .clr(err_clr),
        .flags(ERR_FLAGS)
    );

    // =====================================================
    // Header classification
    always_comb begin
        hdr_ok = parity_ok(HDR_ID);
        hdr_st = ST_SKIP;
        hdr_kind = FK_NONE;
        hdr_len = id_len(HDR_ID[5:4]);
        resp_cmd = 7'h00;
        if (!hdr_ok) begin
            // Corrupt header, frame ignored
            hdr_st = ST_SKIP;
        end else if (hid == `LSFD_ID_CMD) begin
            hdr_st = ST_RX; // [R7]
            hdr_kind = FK_CMD;
            hdr_len = `LSFD_LEN8;
        end else if (hid == `LSFD_ID_RDIND) begin
            // Answer only the frame after a prepare
            if (prep_q) begin
                hdr_st = ST_TX; // [R14] [R17]
                resp_cmd = prep_cmd_q;
                hdr_len = `LSFD_LEN8;
            end
        end else if (hid == ID_MAP.dread) begin
            hdr_st = ST_TX; // [R16]
            resp_cmd = ID_MAP.dread_cmd;
        end else if (hid == ID_MAP.prep && !HDR_ID[5]) begin
            hdr_st = ST_RX; // [R19]
            hdr_kind = FK_PREP;
        end else if (hid == ID_MAP.gp2 || hid == ID_MAP.gp4) begin
            hdr_st = ST_RX; // [R9]
            hdr_kind = FK_GP;
        end else if (hid == ID_MAP.appw) begin
            hdr_st = ST_RX; // [R11]
            hdr_kind = FK_APPW;
        end else if (hid == ID_MAP.nodew) begin
            hdr_st = ST_RX; // [R12]
            hdr_kind = FK_NODEW;
            hdr_len = `LSFD_LEN2;
        end
    end

    // =====================================================
    // Frame state, a new header always restarts
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            st_q <= ST_IDLE;
        end else if (HDR_VALID) begin
            st_q <= hdr_st;
        end else if (FRAME_END) begin
            st_q <= ST_IDLE;
        end
    end

    // Frame kind and expected length, held for the frame
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            kind_q <= FK_NONE;
            len_q <= `LSFD_LEN2;
        end else if (HDR_VALID) begin
            kind_q <= hdr_kind;
            len_q <= hdr_len;
        end
    end

    // =====================================================
    // Byte counter, saturates so long frames still fail
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            cnt_q <= 4'h0;
        end else if (HDR_VALID) begin
            cnt_q <= 4'h0;
        end else if (RX_VALID && st_q == ST_RX && cnt_q != 4'hF) begin
            cnt_q <= cnt_q + 4'h1;
        end
    end

    // Data bytes, stored by index
    always_ff @(posedge MCLK) begin
        if (RX_VALID && st_q == ST_RX && !cnt_q[3]) begin
            buf_q[cnt_q[2:0]] <= RX_BYTE;
        end
    end

    // Stop bit fault remembered until the next header
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            stop_q <= 1'b0;
        end else if (HDR_VALID) begin
            stop_q <= 1'b0;
        end else if (RX_STOP_ERR && st_q == ST_RX) begin
            stop_q <= 1'b1;
        end
    end

    // =====================================================
    // End of writing frame: decide execute and arm
    always_comb begin
        len_ok = (cnt_q == len_q);
        rx_good = (st_q == ST_RX) && CHKSUM_OK && len_ok && !stop_q;
        exec = 1'b0;
        arm = 1'b0;
        code = buf_q[0][6:0];
        case (kind_q)
            FK_CMD: begin
                // Marker gates the command byte
                code = buf_q[1][6:0];
                if (buf_q[0] == `LSFD_MARKER && buf_q[1][7]) begin // [R21]
                    exec = !buf_q[2][`LSFD_BROAD_BIT] || hit(buf_q[2]); // [R23]
                    arm = buf_q[2][`LSFD_BROAD_BIT] && hit(buf_q[2]); // [R20]
                end
            end
            FK_GP: begin
                // Select bit zero reaches every node
                exec = !buf_q[1][`LSFD_BROAD_BIT] || hit(buf_q[1]); // [R9] [R10]
            end
            FK_PREP: begin
                arm = buf_q[0][7] && buf_q[1][7] && hit(buf_q[1]); // [R18] [R19]
            end
            FK_APPW: begin
                exec = 1'b1; // [R11]
                code = ID_MAP.appw_cmd;
            end
            FK_NODEW: begin
                exec = 1'b1; // [R12]
                code = ID_MAP.nodew_cmd;
            end
            default: begin
                exec = 1'b0;
            end
        endcase
    end

    // Flatten stored bytes, byte 1 in the low lane
    always_comb begin
        data_w = 64'h0;
        for (int i = 0; i < 8; i++) begin
            data_w[i*8 +: 8] = buf_q[i];
        end
    end

    // =====================================================
    // Command output, one pulse per clean frame that executes
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            CMD_VALID <= 1'b0;
            CMD <= '0;
        end else begin
            CMD_VALID <= FRAME_END && rx_good && exec;
            if (FRAME_END && rx_good && exec) begin
                CMD <= '{code: code, len: len_q, data: data_w};
            end
        end
    end

    // =====================================================
    // Prepared response lives for exactly one frame
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            prep_q <= 1'b0;
            prep_cmd_q <= 7'h00;
        end else if (HDR_VALID) begin
            prep_q <= 1'b0; // [R14]
        end else if (FRAME_END && rx_good && arm) begin
            prep_q <= 1'b1; // [R18]
            prep_cmd_q <= code;
        end
    end

    // =====================================================
    // Response request, own address always attached
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            RESP_REQ <= 1'b0;
            RESP <= '0;
        end else begin
            RESP_REQ <= HDR_VALID && hdr_st == ST_TX; // [R13]
            if (HDR_VALID && hdr_st == ST_TX) begin
                RESP <= '{cmd: resp_cmd, node_addr: NODE_ADDR,
                    len: hdr_len}; // [R15]
            end
        end
    end

    // =====================================================
    // Error events into the sticky register
    always_comb begin
        err_set = 4'h0;
        err_set[`LSFD_EB_TIMEOUT] = TIMEOUT_ERR; // [R1]
        err_set[`LSFD_EB_DATA] = (st_q == ST_RX) && ((RX_STOP_ERR) ||
            (FRAME_END && (!CHKSUM_OK || !len_ok))); // [R2]
        err_set[`LSFD_EB_HDR] = SYNC_ERR ||
            (HDR_VALID && !hdr_ok); // [R3]
        err_set[`LSFD_EB_BIT] = (st_q == ST_TX) && TX_BIT_VALID &&
            (TX_BIT_SENT != TX_BIT_READ); // [R24]
        err_clr = HDR_VALID && hdr_st == ST_TX &&
            resp_cmd == `LSFD_CMD_FULLSTAT; // [R4]
    end

    // =====================================================
    // Checks
    default clocking @(posedge MCLK); endclocking
    default disable iff (!RESET_N);

    sequence s_prep_done;
        st_q == ST_RX && FRAME_END && rx_good && arm;
    endsequence

    sequence s_ind_hdr;
        HDR_VALID && parity_ok(HDR_ID) && hid == `LSFD_ID_RDIND;
    endsequence

    a_prep_answer: assert property ( // [R14]
        s_prep_done ##1 !HDR_VALID ##1 s_ind_hdr |=> RESP_REQ &&
        RESP.node_addr == NODE_ADDR && RESP.len == `LSFD_LEN8)
        else $error("prepared indirect read not answered");
    a_ind_unprep: assert property ( // [R17]
        (s_ind_hdr and (!prep_q)) |=> !RESP_REQ)
        else $error("indirect read answered unprepared");
    a_hdr_parity: assert property ( // [R3]
        (HDR_VALID && !parity_ok(HDR_ID)) |=>
        ERR_FLAGS[`LSFD_EB_HDR] && !RESP_REQ)
        else $error("parity fault not flagged");
    a_marker_gate: assert property ( // [R21]
        (FRAME_END && st_q == ST_RX && kind_q == FK_CMD &&
        buf_q[0] != `LSFD_MARKER) |=> !CMD_VALID)
        else $error("command taken without marker");
    a_len_error: assert property ( // [R2]
        (FRAME_END && st_q == ST_RX && cnt_q != len_q) |=>
        ERR_FLAGS[`LSFD_EB_DATA] && !CMD_VALID)
        else $error("length fault not flagged");
    a_bit_error: assert property ( // [R24]
        (st_q == ST_TX && TX_BIT_VALID && TX_BIT_SENT != TX_BIT_READ)
        |=> ERR_FLAGS[`LSFD_EB_BIT])
        else $error("readback fault not flagged");
    a_gp_select: assert property ( // [R10]
        (FRAME_END && st_q == ST_RX && kind_q == FK_GP &&
        buf_q[1][7] && buf_q[1][6:0] != NODE_ADDR) |=> !CMD_VALID)
        else $error("addressed command taken by wrong node");
endmodule // lsfd_frame_decoder

// >>> inc/lsfd_params.svh
`ifndef LSFD_PARAMS_SVH
`define LSFD_PARAMS_SVH
// =====================================================
// Reserved identifiers, marker and full status command values
`define LSFD_ID_CMD 6'h3C
`define LSFD_ID_RDIND 6'h3D
`define LSFD_MARKER 8'h80
`define LSFD_CMD_FULLSTAT 7'h01
// =====================================================
// Error flag bit positions and reset value
`define LSFD_EB_TIMEOUT 3
`define LSFD_EB_DATA 2
`define LSFD_EB_HDR 1
`define LSFD_EB_BIT 0
`define LSFD_ERR_RST 8'h00
// =====================================================
// Data field lengths in bytes
`define LSFD_LEN2 4'h2
`define LSFD_LEN4 4'h4
`define LSFD_LEN8 4'h8
// Select bit of an address byte
`define LSFD_BROAD_BIT 7
`endif

// >>> inc/lsfd_pkg.sv
package lsfd_pkg;
    // =====================================================
    // Frame handling states, one-hot
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_RX = 4'h2,
        ST_TX = 4'h4,
        ST_SKIP = 4'h8
    } lsfd_state_t;
    // Kind of writing frame being received
    typedef enum logic [2:0] {
        FK_CMD = 3'h0,
        FK_GP = 3'h1,
        FK_PREP = 3'h2,
        FK_APPW = 3'h3,
        FK_NODEW = 3'h4,
        FK_NONE = 3'h7
    } lsfd_kind_t;
    // Dynamic identifier bindings from the ID table
    typedef struct packed {
        logic [5:0] gp2;
        logic [5:0] gp4;
        logic [5:0] prep;
        logic [5:0] appw;
        logic [5:0] nodew;
        logic [5:0] dread;
        logic [6:0] appw_cmd;
        logic [6:0] nodew_cmd;
        logic [6:0] dread_cmd;
    } lsfd_idmap_t;
    // Command handed to the application
    typedef struct packed {
        logic [6:0] code;
        logic [3:0] len;
        logic [63:0] data;
    } lsfd_cmd_t;
    // Response request for a reading frame
    typedef struct packed {
        logic [6:0] cmd;
        logic [6:0] node_addr;
        logic [3:0] len;
    } lsfd_resp_t;
endpackage

// >>> verilog/lsfd_node_addr.sv
`include "lsfd_params.svh"
module lsfd_node_addr import lsfd_pkg::*; (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [3:0] prog,
    input wire logic [2:0] pin,
    output logic [6:0] addr
);
    // =====================================================
    // Strap synchronisers
    logic [2:0] s1_q; // First stage, read only by s2_q
    logic [2:0] s2_q; // Settled strap levels
    logic [1:0] warm_q; // Checker warm-up count

    // Straps are board levels, but still async to MCLK
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_q <= 3'h0;
            s2_q <= 3'h0;
        end else begin
            s1_q <= pin;
            s2_q <= s1_q;
        end
    end

    // =====================================================
    // Address register, pin 0 lands in the top bit
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            addr <= 7'h00;
        end else begin
            addr <= {s2_q[0], s2_q[1], s2_q[2], prog}; // [R5]
        end
    end

    // Warm-up so the check skips reset history
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            warm_q <= 2'h0;
        end else if (warm_q != 2'h3) begin
            warm_q <= warm_q + 2'h1;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_addr_compose: assert property ( // [R5]
        (warm_q == 2'h3) |-> (addr == {$past(pin[0], 3),
        $past(pin[1], 3), $past(pin[2], 3), $past(prog)}))
        else $error("node address not composed from straps");
endmodule // lsfd_node_addr

// >>> verilog/lsfd_err_reg.sv
`include "lsfd_params.svh"
module lsfd_err_reg import lsfd_pkg::*; (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [3:0] set,
    input wire logic clr,
    output logic [7:0] flags
);
    // =====================================================
    // Sticky flags, a set in the clear cycle survives
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flags <= `LSFD_ERR_RST;
        end else begin
            flags <= {4'h0, (clr ? 4'h0 : flags[3:0]) | set}; // [R1] [R25]
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_flags_sticky: assert property ( // [R25]
        !clr |=> ((flags[3:0] & $past(flags[3:0]))
        == $past(flags[3:0])))
        else $error("error flag dropped without clear");
    a_clear_all: assert property ( // [R4]
        (clr && set == 4'h0) |=> (flags == 8'h00))
        else $error("error register not cleared");
    a_set_wins: assert property ( // [R25]
        (set != 4'h0) |=> ((flags[3:0] & $past(set)) == $past(set)))
        else $error("error event lost");
    a_upper_zero: assert property ( // [R1]
        flags[7:4] == 4'h0)
        else $error("unused error bits not zero");
endmodule // lsfd_err_reg

// >>> testbench/lsfd_master_model.sv
// ==========================================
// Bus master: headers, bytes, frame ends
module lsfd_master_model import lsfd_pkg::*; (
    input wire logic clk,
    output logic hdr_valid,
    output logic [7:0] hdr_id,
    output logic rx_valid,
    output logic [7:0] rx_byte,
    output logic rx_stop_err,
    output logic frame_end,
    output logic chksum_ok,
    output logic tx_bit_valid,
    output logic tx_bit_sent,
    output logic tx_bit_read
);
    timeunit 1ns;
    timeprecision 1ps;

    // Quiet bus at time zero
    initial begin
        hdr_valid = 1'b0;
        hdr_id = 8'h00;
        rx_valid = 1'b0;
        rx_byte = 8'h00;
        rx_stop_err = 1'b0;
        frame_end = 1'b0;
        chksum_ok = 1'b0;
        tx_bit_valid = 1'b0;
        tx_bit_sent = 1'b0;
        tx_bit_read = 1'b0;
    end

    // Six id bits under two parity bits
    function automatic logic [7:0] prot_id(input logic [5:0] id);
        return {~(id[1] ^ id[3] ^ id[4] ^ id[5]),
                id[0] ^ id[1] ^ id[2] ^ id[4], id};
    endfunction

    // Header, scrambled once released
    task automatic header(input logic [7:0] idb);
        @(negedge clk);
        hdr_valid = 1'b1;
        hdr_id = idb;
        @(negedge clk);
        hdr_valid = 1'b0;
        hdr_id = ~idb;
    endtask

    // Writing frame, bytes low first
    task automatic write_frame(input logic [5:0] id,
        input logic [63:0] data, input int n, input logic ok = 1'b1);
        header(prot_id(id));
        for (int k = 0; k < n; k++) begin
            rx_valid = 1'b1;
            rx_byte = data[8*k +: 8];
            @(negedge clk);
        end
        rx_valid = 1'b0;
        rx_byte = ~rx_byte;
        frame_end = 1'b1;
        chksum_ok = ok;
        @(negedge clk);
        frame_end = 1'b0;
        chksum_ok = ~ok;
    endtask

    // Reading frame, one readback bit
    task automatic read_frame(input logic [5:0] id, input logic bad = 1'b0);
        header(prot_id(id));
        repeat (4) @(negedge clk);
        tx_bit_valid = 1'b1;
        tx_bit_sent = 1'b1;
        tx_bit_read = ~bad;
        @(negedge clk);
        tx_bit_valid = 1'b0;
        frame_end = 1'b1;
        chksum_ok = 1'b1;
        @(negedge clk);
        frame_end = 1'b0;
    endtask
endmodule // lsfd_master_model

// >>> testbench/test_lin_slave_frame_decoder.sv
`include "lsfd_params.svh"
// ==========================================
// Frame decoder bench
module test_lin_slave_frame_decoder import lsfd_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [6:0] MY_ADDR = 7'h5A; // Straps 101, memory 1010
    localparam int CYC_MAX = 20000; // Ample margin
    logic MCLK = 1'b0;
    logic RESET_N = 1'b0;
    logic [3:0] prog = 4'hA;
    logic [2:0] strap = 3'b101; // Pin0 is the top address bit
    lsfd_idmap_t id_map = '{gp2: 6'h18, gp4: 6'h28, prep: 6'h1A,
        appw: 6'h30, nodew: 6'h05, dread: 6'h22, appw_cmd: 7'h0B,
        nodew_cmd: 7'h0C, dread_cmd: 7'h00};
    logic sync_err = 1'b0, timeout_err = 1'b0;
    logic hv, rv, se, fe, ck, tv, ts, tr, cmd_valid, resp_req;
    logic [7:0] hid, rb, err_flags;
    logic [6:0] node_addr;
    lsfd_cmd_t cmd, last_cmd;
    lsfd_resp_t resp, last_resp;
    int err_count = 0, tests_run = 0, cycles = 0;
    int cmd_cnt = 0, cmd_base = 0, resp_cnt = 0, resp_base = 0;

    // ==========================================
    // Clock, watchdog and output monitor
    always #4 MCLK = ~MCLK;

    // Stuck run fails
    always @(posedge MCLK) begin
        cycles++;
        if (cycles == CYC_MAX) begin
            err_count++;
            $display("CHECK FAILED timeout expected end seen hang");
            conclude();
        end
    end

    // Pulses caught where settled
    always @(negedge MCLK) begin
        if (cmd_valid === 1'b1) begin
            cmd_cnt++;
            last_cmd = cmd;
        end
        if (resp_req === 1'b1) begin
            resp_cnt++;
            last_resp = resp;
        end
    end

    lsfd_master_model u_bm (.clk(MCLK), .hdr_valid(hv), .hdr_id(hid),
        .rx_valid(rv), .rx_byte(rb), .rx_stop_err(se), .frame_end(fe),
        .chksum_ok(ck), .tx_bit_valid(tv), .tx_bit_sent(ts),
        .tx_bit_read(tr));

    lsfd_frame_decoder u_dut (.MCLK(MCLK), .RESET_N(RESET_N),
        .PROG_ADDR_BIT0(prog[0]), .PROG_ADDR_BIT1(prog[1]),
        .PROG_ADDR_BIT2(prog[2]), .PROG_ADDR_BIT3(prog[3]),
        .STRAP_ADDR_PIN0(strap[2]), .STRAP_ADDR_PIN1(strap[1]),
        .STRAP_ADDR_PIN2(strap[0]), .ID_MAP(id_map), .HDR_VALID(hv),
        .HDR_ID(hid), .SYNC_ERR(sync_err), .RX_VALID(rv), .RX_BYTE(rb),
        .RX_STOP_ERR(se), .FRAME_END(fe), .CHKSUM_OK(ck),
        .TIMEOUT_ERR(timeout_err), .TX_BIT_VALID(tv), .TX_BIT_SENT(ts),
        .TX_BIT_READ(tr), .CMD_VALID(cmd_valid), .CMD(cmd),
        .RESP_REQ(resp_req), .RESP(resp), .ERR_FLAGS(err_flags),
        .NODE_ADDR(node_addr));

    // ==========================================
    // Compare helpers
    task automatic check(input string name, input logic [63:0] seen,
        input logic [63:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %0h seen %0h", name, exp,
                     seen);
        end
    endtask

    // New commands, latest kept
    task automatic chk_cmd(input string name, input int n,
        input logic [6:0] code = 7'h00, input logic [3:0] len = 4'h0);
        repeat (3) @(negedge MCLK);
        check({name, " n"}, cmd_cnt - cmd_base, n);
        cmd_base = cmd_cnt;
        if (n > 0) begin
            check({name, " code"}, last_cmd.code, code);
            check({name, " len"}, last_cmd.len, len);
        end
    endtask

    // New answers, address always present
    task automatic chk_resp(input string name, input int n,
        input logic [6:0] code = 7'h00, input logic [3:0] len = 4'h0);
        repeat (3) @(negedge MCLK);
        check({name, " n"}, resp_cnt - resp_base, n);
        resp_base = resp_cnt;
        if (n > 0) begin
            check({name, " cmd"}, last_resp.cmd, code);
            check({name, " len"}, last_resp.len, len);
            check({name, " addr"}, last_resp.node_addr, MY_ADDR);
        end
    endtask

    // Timeout or bad sync pulse
    task automatic bit_layer_pulse(input logic is_timeout);
        @(negedge MCLK);
        timeout_err = is_timeout;
        sync_err = ~is_timeout;
        @(negedge MCLK);
        timeout_err = 1'b0;
        sync_err = 1'b0;
        repeat (2) @(negedge MCLK);
    endtask

    // Single exit point of the run
    task automatic conclude();
        $display("Counts: %0d checks, %0d mismatches", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // ==========================================
    // Main sequence
    initial begin
        repeat (4) @(negedge MCLK);
        RESET_N = 1'b1;
        repeat (4) @(negedge MCLK);
        check("reset flags", err_flags, 8'h00);
        check("node address", node_addr, MY_ADDR);
        $display("Test reset done");
        // Writing frames of every kind except prepare
        u_bm.write_frame(id_map.gp2, 64'h0005, 2);
        chk_cmd("gp2 broadcast", 1, 7'h05, `LSFD_LEN2);
        u_bm.write_frame(id_map.gp4, 64'h2211BA07, 4);
        chk_cmd("gp4 other", 0);
        u_bm.write_frame(id_map.gp4, 64'h2211DA07, 4);
        chk_cmd("gp4 own node", 1, 7'h07, `LSFD_LEN4);
        u_bm.write_frame(`LSFD_ID_CMD, 64'h0504030201DA8980, 8);
        chk_cmd("cmd frame", 1, 7'h09, `LSFD_LEN8);
        check("cmd data", last_cmd.data, 64'h0504030201DA8980);
        u_bm.write_frame(`LSFD_ID_CMD, 64'h0504030201DA8900, 8);
        chk_cmd("no marker", 0);
        u_bm.write_frame(`LSFD_ID_CMD, 64'h0504030201BA8980, 8);
        chk_cmd("cmd other", 0);
        u_bm.write_frame(id_map.appw, 64'h1122334455667788, 8);
        chk_cmd("app bound", 1, 7'h0B, `LSFD_LEN8);
        u_bm.write_frame(id_map.nodew, 64'h3344, 2);
        chk_cmd("node bound", 1, 7'h0C, `LSFD_LEN2);
        $display("Test writes done");
        // Reading frames, direct and indirect
        u_bm.read_frame(`LSFD_ID_RDIND);
        chk_resp("unprepared", 0);
        u_bm.write_frame(id_map.prep, 64'hBA83, 2);
        u_bm.read_frame(`LSFD_ID_RDIND);
        chk_resp("prep other", 0);
        u_bm.write_frame(id_map.prep, 64'hDA83, 2);
        chk_cmd("prep no cmd", 0);
        u_bm.read_frame(`LSFD_ID_RDIND);
        chk_resp("prep short", 1, 7'h03, `LSFD_LEN8);
        u_bm.write_frame(`LSFD_ID_CMD, 64'h0504030201DA8480, 8);
        chk_cmd("cmd prep", 1, 7'h04, `LSFD_LEN8);
        u_bm.read_frame(`LSFD_ID_RDIND);
        chk_resp("prep long", 1, 7'h04, `LSFD_LEN8);
        u_bm.read_frame(id_map.dread);
        chk_resp("direct read", 1, 7'h00, `LSFD_LEN4);
        $display("Test reads done");
        // Error flags: set, sticky, cleared by the status query
        u_bm.header(u_bm.prot_id(id_map.gp2) ^ 8'h80);
        repeat (2) @(negedge MCLK);
        check("parity flag", err_flags, 8'h02);
        u_bm.write_frame(id_map.gp2, 64'h0006, 2);
        chk_cmd("after parity", 1, 7'h06, `LSFD_LEN2);
        check("flag sticky", err_flags, 8'h02);
        u_bm.write_frame(id_map.gp2, 64'h0006, 2, 1'b0);
        chk_cmd("bad checksum", 0);
        check("checksum flag", err_flags, 8'h06);
        bit_layer_pulse(1'b1);
        check("timeout flag", err_flags, 8'h0E);
        u_bm.read_frame(id_map.dread, 1'b1);
        chk_resp("read bit err", 1, 7'h00, `LSFD_LEN4);
        check("bit flag", err_flags, 8'h0F);
        u_bm.write_frame(id_map.prep, 64'hDA81, 2);
        u_bm.read_frame(`LSFD_ID_RDIND);
        chk_resp("status query", 1, `LSFD_CMD_FULLSTAT, `LSFD_LEN8);
        check("flags cleared", err_flags, 8'h00);
        bit_layer_pulse(1'b0);
        check("sync flag", err_flags, 8'h02);
        u_bm.write_frame(id_map.gp2, 64'h070006, 3);
        chk_cmd("long frame", 0);
        check("length flag", err_flags, 8'h06);
        $display("Test errors done");
        conclude();
    end
endmodule // test_lin_slave_frame_decoder
